// ==== exc_regs.vh ====
`ifndef EXC_REGS_VH
`define EXC_REGS_VH
// Cause codes (standard encoding)
`define CODE_TLB_LOAD 5'h02
`define CODE_TLB_STORE 5'h03
`define CODE_ADDR_LOAD 5'h04
`define CODE_ADDR_STORE 5'h05
// Vectors
`define VEC_RESET 64'hFFFFFFFFBFC00000
`define VEC_REFILL_BEV0 64'hFFFFFFFF80000000
`define VEC_REFILL_BEV1 64'hFFFFFFFFBFC00200
`define OFS_XREFILL 64'h0000000000000080
`define OFS_COMMON 64'h0000000000000180
// Register offsets
`define REG_STATUS 4'h0
`define REG_CAUSE 4'h1
`define REG_RESTART 4'h2
`define REG_ERR_RESTART 4'h3
`define REG_BAD_ADDR 4'h4
`define REG_ENTRY_HIGH 4'h5
`define REG_CONTEXT 4'h6
`define REG_XCONTEXT 4'h7
`define REG_VECTOR 4'h8
`define REG_ENTRY_LOW 4'h9
// Status bit positions
`define ST_IE 0
`define ST_EXL 1
`define ST_ERL 2
`define ST_KSU_LO 3
`define ST_UX 5
`define ST_SX 6
`define ST_KX 7
`define ST_SR 20
`define ST_TS 21
`define ST_BEV 22
`define STATUS_RST 32'h00400004
// Cause bit positions
`define CA_CODE_LO 2
`define CA_BD 31
`endif

// ==== exc_fault_detect.v ====
`timescale 1ns/1ps
`include "exc_regs.vh"
module exc_fault_detect (
   input wire [63:0] vaddr,
   input wire [1:0] size,
   input wire is_cache,
   input wire is_jump,
   input wire [1:0] mode,
   input wire wide,
   output reg addr_err
);
   reg misalign;
   reg bad_space;
   always @* begin
      misalign = 1'b0;
      bad_space = 1'b0;
      // size: 0 byte, 1 half, 2 word, 3 double
      case (size)
         2'h1: misalign = vaddr[0];
         2'h2: misalign = |vaddr[1:0];
         2'h3: misalign = |vaddr[2:0];
         default: misalign = 1'b0;
      endcase
      if ((is_cache || is_jump) && |vaddr[1:0])
         misalign = 1'b1;
      if (!wide) begin
         // 32-bit space: kseg above 8000_0000, sseg C000_0000-DFFF_FFFF
         if (mode != 2'h0 && vaddr[31] && !(mode == 2'h1 && vaddr[31:29] == 3'h6))
            bad_space = 1'b1;
      end else begin
         if (mode != 2'h0 && vaddr[63:62] == 2'h3 && !(mode == 2'h1 && vaddr[61:40] == 22'h3FFFFF))
            bad_space = 1'b1;
         if (mode == 2'h2 && vaddr[63:62] == 2'h1)
            bad_space = 1'b1;
         if (vaddr[63:62] != 2'h2 && |vaddr[61:40] && !(vaddr[63:62] == 2'h3))
            bad_space = 1'b1;
      end
      addr_err = misalign || bad_space;
   end
endmodule // exc_fault_detect

// ==== exc_unit.v ====
`timescale 1ns/1ps
`include "exc_regs.vh"
module exc_unit (
   input wire clk,
   input wire srst,
   input wire cold_reset_n,
   input wire reset_n,
   input wire nmi,
   input wire boundary,
   input wire [63:0] pc,
   input wire in_delay_slot,
   input wire [63:0] branch_pc,
   input wire fetch_valid,
   input wire [63:0] fetch_addr,
   input wire fetch_mapped,
   input wire fetch_tlb_hit,
   input wire fetch_tlb_valid,
   input wire data_valid,
   input wire data_store,
   input wire data_cache_op,
   input wire [1:0] data_size,
   input wire [63:0] data_addr,
   input wire data_mapped,
   input wire data_tlb_hit,
   input wire data_tlb_valid,
   input wire jump_valid,
   input wire [63:0] jump_target,
   input wire [3:0] reg_addr,
   input wire [63:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [63:0] reg_rdata,
   output reg exc_taken,
   output reg [63:0] exc_vector,
   output reg abort_access,
   output reg machines_reset
);
   localparam ST_RUN = 3'h1;
   localparam ST_WARM = 3'h2;
   localparam ST_COLD = 3'h4;
   reg [2:0] state_q;
   reg [31:0] status_q;
   reg [31:0] cause_q;
   reg [63:0] restart_pc_q;
   reg [63:0] error_restart_pc_q;
   reg [63:0] bad_address_reg_q;
   reg [63:0] entry_high_reg_q;
   reg [63:0] context_q;
   reg [63:0] xcontext_q;
   reg [63:0] entry_low_reg_q;
   reg nmi_q;
   // Mode code: 0 kernel, 1 supervisor, 2 user; either level flag forces kernel
   wire [1:0] mode = (status_q[`ST_EXL] || status_q[`ST_ERL]) ? 2'h0 : status_q[4:3];
   wire wide = (mode == 2'h0) ? status_q[`ST_KX] :
      (mode == 2'h1) ? status_q[`ST_SX] : status_q[`ST_UX];
   wire fetch_ae;
   wire data_ae;
   wire jump_ae;
   exc_fault_detect u_fetch (
      .vaddr(fetch_addr), .size(2'h2), .is_cache(1'b0), .is_jump(1'b0),
      .mode(mode), .wide(wide), .addr_err(fetch_ae)
   );
   exc_fault_detect u_data (
      .vaddr(data_addr), .size(data_size), .is_cache(data_cache_op), .is_jump(1'b0),
      .mode(mode), .wide(wide), .addr_err(data_ae)
   );
   exc_fault_detect u_jump (
      .vaddr(jump_target), .size(2'h0), .is_cache(1'b0), .is_jump(1'b1),
      .mode(mode), .wide(wide), .addr_err(jump_ae)
   );
   wire nmi_rise = nmi && !nmi_q;
   reg nmi_pend_q;
   // Fault classification in priority order
   reg [2:0] kind; // 0 none,1 addr,2 refill,3 invalid
   reg is_store;
   reg [63:0] fault_addr;
   always @* begin
      kind = 3'h0;
      is_store = 1'b0;
      fault_addr = 64'h0000000000000000;
      if (fetch_valid && (fetch_ae || (jump_valid && jump_ae))) begin
         kind = 3'h1;
         fault_addr = fetch_ae ? fetch_addr : jump_target;
      end else if (fetch_valid && fetch_mapped && !fetch_tlb_hit) begin
         kind = 3'h2;
         fault_addr = fetch_addr;
      end else if (fetch_valid && fetch_mapped && !fetch_tlb_valid) begin
         kind = 3'h3;
         fault_addr = fetch_addr;
      end else if (data_valid && data_ae) begin
         kind = 3'h1;
         is_store = data_store;
         fault_addr = data_addr;
      end else if (data_valid && data_mapped && !data_tlb_hit) begin
         kind = 3'h2;
         is_store = data_store;
         fault_addr = data_addr;
      end else if (data_valid && data_mapped && !data_tlb_valid) begin
         kind = 3'h3;
         is_store = data_store;
         fault_addr = data_addr;
      end
   end
   wire [63:0] refill_base = status_q[`ST_BEV] ? `VEC_REFILL_BEV1 : `VEC_REFILL_BEV0;
   wire [63:0] common_vec = refill_base + `OFS_COMMON;
   wire take_nmi = nmi_pend_q && boundary;
   always @(posedge clk) begin
      if (srst) begin
         state_q <= ST_COLD;
         status_q <= `STATUS_RST;
         cause_q <= 32'h00000000;
         restart_pc_q <= 64'h0000000000000000;
         error_restart_pc_q <= 64'h0000000000000000;
         bad_address_reg_q <= 64'h0000000000000000;
         entry_high_reg_q <= 64'h0000000000000000;
         context_q <= 64'h0000000000000000;
         xcontext_q <= 64'h0000000000000000;
         entry_low_reg_q <= 64'h0000000000000000;
         nmi_q <= 1'b0;
         nmi_pend_q <= 1'b0;
         exc_taken <= 1'b0;
         exc_vector <= `VEC_RESET;
         abort_access <= 1'b0;
         machines_reset <= 1'b1;
         reg_rdata <= 64'h0000000000000000;
      end else begin
         nmi_q <= nmi;
         exc_taken <= 1'b0;
         abort_access <= 1'b0;
         machines_reset <= 1'b0;
         reg_rdata <= 64'h0000000000000000;
         if (nmi_rise)
            nmi_pend_q <= 1'b1;
         if (reg_rd) begin
            case (reg_addr)
               `REG_STATUS: reg_rdata <= {32'h00000000, status_q};
               `REG_CAUSE: reg_rdata <= {32'h00000000, cause_q};
               `REG_RESTART: reg_rdata <= restart_pc_q;
               `REG_ERR_RESTART: reg_rdata <= error_restart_pc_q;
               `REG_BAD_ADDR: reg_rdata <= bad_address_reg_q;
               `REG_ENTRY_HIGH: reg_rdata <= entry_high_reg_q;
               `REG_CONTEXT: reg_rdata <= context_q;
               `REG_XCONTEXT: reg_rdata <= xcontext_q;
               `REG_VECTOR: reg_rdata <= exc_vector;
               `REG_ENTRY_LOW: reg_rdata <= entry_low_reg_q;
               default: reg_rdata <= 64'h0000000000000000;
            endcase
         end
         if (reg_wr) begin
            case (reg_addr)
               `REG_STATUS: status_q <= reg_wdata[31:0];
               `REG_CAUSE: cause_q <= reg_wdata[31:0];
               `REG_RESTART: restart_pc_q <= reg_wdata;
               `REG_ERR_RESTART: error_restart_pc_q <= reg_wdata;
               `REG_ENTRY_HIGH: entry_high_reg_q <= reg_wdata;
               `REG_CONTEXT: context_q <= reg_wdata;
               `REG_XCONTEXT: xcontext_q <= reg_wdata;
               `REG_ENTRY_LOW: entry_low_reg_q <= reg_wdata;
               default: ;
            endcase
         end
         case (state_q)
            ST_COLD: begin
               machines_reset <= 1'b1;
               if (reset_n && cold_reset_n) begin
                  state_q <= ST_RUN;
                  exc_taken <= 1'b1;
                  exc_vector <= `VEC_RESET;
               end
            end
            ST_RUN: begin
               if (!cold_reset_n) begin
                  state_q <= ST_COLD;
               end else if (!reset_n) begin
                  state_q <= ST_WARM;
                  machines_reset <= 1'b1;
                  abort_access <= 1'b1;
                  if (!status_q[`ST_ERL])
                     error_restart_pc_q <= pc;
                  status_q[`ST_TS] <= 1'b0;
                  status_q[`ST_ERL] <= 1'b1;
                  status_q[`ST_SR] <= 1'b1;
                  status_q[`ST_BEV] <= 1'b1;
                  nmi_pend_q <= 1'b0;
               end else if (take_nmi) begin
                  nmi_pend_q <= 1'b0;
                  exc_taken <= 1'b1;
                  exc_vector <= `VEC_RESET;
                  if (!status_q[`ST_ERL])
                     error_restart_pc_q <= pc;
                  status_q[`ST_TS] <= 1'b0;
                  status_q[`ST_ERL] <= 1'b1;
                  status_q[`ST_SR] <= 1'b1;
                  status_q[`ST_BEV] <= 1'b1;
               end else if (kind != 3'h0) begin
                  exc_taken <= 1'b1;
                  status_q[`ST_EXL] <= 1'b1;
                  if (!status_q[`ST_EXL]) begin
                     restart_pc_q <= in_delay_slot ? branch_pc : pc;
                     cause_q[`CA_BD] <= in_delay_slot;
                  end
                  bad_address_reg_q <= fault_addr;
                  if (kind == 3'h1) begin
                     cause_q[6:2] <= is_store ? `CODE_ADDR_STORE : `CODE_ADDR_LOAD;
                     exc_vector <= common_vec;
                  end else begin
                     cause_q[6:2] <= is_store ? `CODE_TLB_STORE : `CODE_TLB_LOAD;
                     entry_high_reg_q <= {fault_addr[63:13], entry_high_reg_q[12:0]};
                     context_q <= {context_q[63:23], fault_addr[31:13], 4'h0};
                     xcontext_q <= {xcontext_q[63:33], fault_addr[63:62],
                        fault_addr[39:11], 2'h0};
                     if (kind == 3'h2 && !status_q[`ST_EXL])
                        exc_vector <= refill_base + (wide ? `OFS_XREFILL : 64'h0);
                     else
                        exc_vector <= common_vec;
                  end
               end
            end
            ST_WARM: begin
               machines_reset <= 1'b1;
               if (!cold_reset_n)
                  state_q <= ST_COLD;
               else if (reset_n) begin
                  state_q <= ST_RUN;
                  exc_taken <= 1'b1;
                  exc_vector <= `VEC_RESET;
               end
            end
            default: state_q <= ST_COLD;
         endcase
      end
   end
endmodule // exc_unit

// ==== exc_unit_monitor.sv ====
`timescale 1ns/1ps
`include "exc_regs.vh"
module exc_unit_chk (
   input wire clk,
   input wire srst,
   input wire cold_reset_n,
   input wire reset_n,
   input wire nmi,
   input wire boundary,
   input wire fetch_valid,
   input wire data_valid,
   input wire [1:0] data_size,
   input wire [63:0] data_addr,
   input wire data_mapped,
   input wire data_tlb_hit,
   input wire data_tlb_valid,
   input wire jump_valid,
   input wire [63:0] jump_target,
   input wire exc_taken,
   input wire abort_access,
   input wire [63:0] exc_vector,
   input wire machines_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire run = reset_n && cold_reset_n && !machines_reset && !nmi && boundary;
   wire mis = data_valid && ((data_size == 2'h1 && data_addr[0])
      || (data_size == 2'h2 && data_addr[1:0] != 2'h0)
      || (data_size == 2'h3 && data_addr[2:0] != 3'h0));
   wire dref = run && !fetch_valid && data_valid && data_mapped && !mis;
   sequence nmi_seen;
      $rose(nmi) && reset_n && cold_reset_n && !machines_reset && boundary;
   endsequence
   sequence nmi_held;
      nmi_seen ##1 boundary;
   endsequence
   vec_hold_a:
      assert property (!exc_taken |-> $stable(exc_vector)) else $error("vector moved");
   align_err_a:
      assert property (run && !fetch_valid && mis |=> exc_taken && exc_vector[8:0] == 9'h180)
      else $error("misaligned access not trapped");
   jump_err_a:
      assert property (run && fetch_valid && jump_valid && jump_target[1:0] != 2'h0
         |=> exc_taken && exc_vector[8:0] == 9'h180) else $error("bad jump not trapped");
   refill_vec_a:
      assert property (dref && !data_tlb_hit |=> exc_taken && (exc_vector[8:0] == 9'h000
         || exc_vector[8:0] == 9'h080 || exc_vector[8:0] == 9'h180)) else $error("no refill");
   invalid_vec_a:
      assert property (dref && data_tlb_hit && !data_tlb_valid
         |=> exc_taken && exc_vector[8:0] == 9'h180) else $error("no invalid trap");
   warm_abort_a:
      assert property (cold_reset_n && !reset_n && !machines_reset |=> abort_access)
      else $error("warm reset did not abort access");
   warm_hold_a:
      assert property (cold_reset_n && !reset_n |=> machines_reset) else $error("no warm reset");
   reset_vec_a:
      assert property ($rose(reset_n) && cold_reset_n |-> ##[1:4] exc_taken
         && exc_vector == `VEC_RESET) else $error("reset vector missing");
   nmi_take_a:
      assert property (nmi_held |-> ##[0:2] exc_taken && exc_vector == `VEC_RESET)
      else $error("nmi not taken");
endmodule // exc_unit_chk
bind exc_unit exc_unit_chk i_exc_unit_chk (.clk, .srst, .cold_reset_n, .reset_n, .nmi,
   .boundary, .fetch_valid, .data_valid, .data_size, .data_addr, .data_mapped, .data_tlb_hit,
   .data_tlb_valid, .jump_valid, .jump_target, .exc_taken, .abort_access, .exc_vector,
   .machines_reset);

// ==== sys_ctrl_model.sv ====
`timescale 1ns/1ps
module sys_ctrl_model (
   input wire clk,
   output reg cold_reset_n,
   output reg reset_n,
   output reg nmi
);
   initial begin
      cold_reset_n = 1'b0;
      reset_n = 1'b0;
      nmi = 1'b0;
   end
   task power_up;
      begin
         @(posedge clk);
         cold_reset_n <= 1'b1;
         reset_n <= 1'b1;
      end
   endtask
   // Not issued by the real system; only here to reach the warm path
   task warm_reset;
      begin
         @(posedge clk);
         reset_n <= 1'b0;
         repeat (4) @(posedge clk);
         reset_n <= 1'b1;
      end
   endtask
   task nmi_pulse;
      begin
         @(posedge clk);
         nmi <= 1'b1;
         repeat (2) @(posedge clk);
         nmi <= 1'b0;
      end
   endtask
endmodule // sys_ctrl_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "exc_regs.vh"
module tb_top;
   reg clk, srst, boundary, in_delay_slot, fetch_valid, fetch_mapped, fetch_tlb_hit;
   reg fetch_tlb_valid, data_valid, data_store, data_cache_op, data_mapped, data_tlb_hit;
   reg data_tlb_valid, jump_valid, reg_wr, reg_rd;
   reg [1:0] data_size;
   reg [3:0] reg_addr;
   reg [63:0] pc, branch_pc, fetch_addr, data_addr, jump_target, reg_wdata, v;
   wire cold_reset_n, reset_n, nmi, exc_taken, abort_access, machines_reset;
   wire [63:0] reg_rdata, exc_vector;
   integer failures, tests_run, i;
   exc_unit i_exc_unit (.clk, .srst, .cold_reset_n, .reset_n, .nmi, .boundary, .pc,
      .in_delay_slot, .branch_pc, .fetch_valid, .fetch_addr, .fetch_mapped, .fetch_tlb_hit,
      .fetch_tlb_valid, .data_valid, .data_store, .data_cache_op, .data_size, .data_addr,
      .data_mapped, .data_tlb_hit, .data_tlb_valid, .jump_valid, .jump_target, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exc_taken, .exc_vector, .abort_access,
      .machines_reset);
   sys_ctrl_model i_sys_ctrl_model (.clk, .cold_reset_n, .reset_n, .nmi);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("comparisons=%0d mismatches=%0d", tests_run, failures);
         if (failures == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task wr(input [3:0] a, input [63:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 v = reg_rdata;
      end
   endtask
   task wt;
      begin
         i = 0;
         while (exc_taken !== 1'b1 && i < 40) begin
            @(posedge clk);
            #1 i = i + 1;
         end
         if (i == 40) begin
            failures = failures + 1;
            results;
         end
      end
   endtask
   // One data (and optionally jump) fault, then the saved state is read back
   task sc(input [63:0] s, input st, input [1:0] sz, input [63:0] a, input mp, input hit,
      input j, input ds, input [63:0] ve, input [4:0] code);
      begin
         wr(`REG_STATUS, s);
         @(posedge clk);
         in_delay_slot <= ds;
         data_valid <= 1'b1;
         data_store <= st;
         data_size <= sz;
         data_addr <= a;
         data_mapped <= mp;
         data_tlb_hit <= hit;
         fetch_valid <= j;
         jump_valid <= j;
         @(posedge clk);
         data_valid <= 1'b0;
         fetch_valid <= 1'b0;
         jump_valid <= 1'b0;
         #1 chk(exc_taken, 1'b1);
         chk(exc_vector, ve);
         rd(`REG_CAUSE);
         chk(v[6:2], code);
         if (!s[1]) begin
            chk(v[31], ds);
            rd(`REG_RESTART);
            chk(v, ds ? branch_pc : pc);
         end
         rd(`REG_BAD_ADDR);
         chk(v, j ? jump_target : a);
         rd(`REG_STATUS);
         chk(v[1], 1'b1);
      end
   endtask
   initial begin
      failures = 0;
      tests_run = 0;
      srst = 1'b1;
      boundary = 1'b1;
      {in_delay_slot, fetch_valid, fetch_mapped, fetch_tlb_hit, fetch_tlb_valid} = 5'h00;
      {data_valid, data_store, data_cache_op, data_mapped, data_tlb_hit} = 5'h00;
      {data_tlb_valid, jump_valid, reg_wr, reg_rd} = 4'h0;
      data_size = 2'h0;
      reg_addr = 4'h0;
      {data_addr, reg_wdata, v} = {64'h0, 64'h0, 64'h0};
      pc = 64'h1000;
      branch_pc = 64'h0FFC;
      fetch_addr = 64'h4000;
      jump_target = 64'h4002;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      i_sys_ctrl_model.power_up;
      wt;
      chk(exc_vector, `VEC_RESET);
      rd(`REG_STATUS);
      chk(v, 64'h00400004);
      rd(4'hF);
      chk(v, 64'h0);
      sc(64'h0, 1, 2'h2, 64'h1002, 0, 0, 0, 0, 64'hFFFFFFFF80000180, 5'h05);
      sc(64'h0, 0, 2'h1, 64'h1001, 0, 0, 0, 1, 64'hFFFFFFFF80000180, 5'h04);
      sc(64'h0, 0, 2'h3, 64'h1004, 0, 0, 0, 0, 64'hFFFFFFFF80000180, 5'h04);
      sc(64'h0, 0, 2'h2, 64'h2000, 1, 0, 0, 1, 64'hFFFFFFFF80000000, 5'h02);
      sc(64'h80, 0, 2'h2, 64'h2000, 1, 0, 0, 0, 64'hFFFFFFFF80000080, 5'h02);
      sc(64'h2, 0, 2'h2, 64'h2000, 1, 0, 0, 0, 64'hFFFFFFFF80000180, 5'h02);
      sc(64'h0, 1, 2'h2, 64'h2000, 1, 1, 0, 0, 64'hFFFFFFFF80000180, 5'h03);
      sc(64'h0, 1, 2'h2, 64'h1002, 0, 0, 1, 0, 64'hFFFFFFFF80000180, 5'h04);
      sc(64'h10, 0, 2'h2, 64'hFFFFFFFF80000000, 0, 0, 0, 0, 64'hFFFFFFFF80000180, 5'h04);
      sc(64'h400000, 0, 2'h2, 64'h2000, 1, 0, 0, 0, 64'hFFFFFFFFBFC00200, 5'h02);
      wr(`REG_STATUS, 64'h2);
      boundary <= 1'b0;
      i_sys_ctrl_model.nmi_pulse;
      repeat (3) @(posedge clk);
      #1 chk(exc_taken, 1'b0);
      boundary <= 1'b1;
      wt;
      chk(exc_vector, `VEC_RESET);
      rd(`REG_ERR_RESTART);
      chk(v, pc);
      rd(`REG_STATUS);
      chk(v, 64'h00500006);
      wr(`REG_STATUS, 64'h0);
      i_sys_ctrl_model.warm_reset;
      #1 chk(machines_reset, 1'b1);
      wt;
      chk(exc_vector, `VEC_RESET);
      rd(`REG_STATUS);
      chk(v[22:20], 3'h5);
      chk(v[2], 1'b1);
      results;
   end
endmodule // tb_top
